/* scp_port.sv */
// module: setup serial port, configuration register and result slave
`timescale 1ns/100ps
// Overview of operation
// RULE1: start bit high begins load on active edge
// RULE2: bits 7,6 decode 0-5, 0-10, +-5 V
// RULE3: bits 7,6 both high select +-10 V
// RULE4: sleep bit low means normal operation
// RULE5: sleep bit high powers down; port stays writable
// RULE6: host clears sleep bit in next write
// RULE7: bits 4,3 decode normal, impulse, warp, normal; the code decodes 01 as warp and 10 as impulse
// RULE8: bit 2 low twos complement, high binary
// RULE9: converter is slave; read after conversion
// RULE10: daisy chain supported in read-after mode
// RULE11: host may read on busy falling edge
// RULE12: host is master, polarity 0, phase 1
// RULE13: host clock limited to 17 Mbps
// RULE14: host may pace conversions from timer
// RULE15: msb first from start bit; ninth edge applies
// RULE16: reset clears configuration to zero
// RULE17: reserved bits 1,0 never updated
// RULE18: port works only in serial software mode
// RULE19: incomplete sequence leaves settings unchanged
module scp_port
  import scp_pkg::*;
(
  // system clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst_b,
  // setup serial port pins, link domain
  input  wire logic               setup_port_clock,
  input  wire logic               setup_port_select_n,
  input  wire logic               setup_port_data_in,
  input  wire logic               clock_edge_invert,
  // interface mode straps
  input  wire logic               serial_sel,
  input  wire logic               hw_config_sel,
  // conversion result from the core
  input  wire logic               conv_done,
  input  wire logic [RES_W-1:0]   conv_result,
  // result read port, link domain
  input  wire logic               read_select_n,
  input  wire logic               chain_data_in,
  output logic                    result_data_out,
  // configuration to the converter core
  output logic                    core_sleep,
  output scp_range_t              input_range,
  output scp_mode_t               conv_mode,
  output logic                    output_coding_sel,
  output logic [SHIFT_W-1:0]      cfg_view
);
  // ---------------- link domain ----------------
  // active edge follows clock_edge_invert; xor gives one clock port
  logic               link_clk;
  logic               frm_clr_b;
  logic               rd_clr_b;
  logic [SHIFT_W-1:0] frm_shifted;
  logic [RES_W-1:0]   res_hold_reg;
  logic               done_tog_l;

  assign link_clk = setup_port_clock ^ clock_edge_invert; // RULE1
  // a raised select must drop a part frame with no clock running
  assign frm_clr_b = rst_b & ~setup_port_select_n; // RULE19
  assign rd_clr_b  = rst_b & ~read_select_n;

  // frame state lives under the select clear; the word does not
  typedef struct packed {
    logic [SHIFT_W-1:0] shreg;
    logic [3:0]         cnt;
    logic               busy;
  } scp_frm_t;

  typedef struct packed {
    logic [SHIFT_W-1:0] word;
    logic               tog;
  } scp_link_t;

  scp_frm_t  fr_reg;
  scp_frm_t  fr_next;
  scp_link_t lk_reg;
  scp_link_t lk_next;

  assign frm_shifted = {fr_reg.shreg[SHIFT_W-2:0], setup_port_data_in};

  always_comb begin
    fr_next = fr_reg;
    lk_next = lk_reg;
    if (!fr_reg.busy) begin
      if (setup_port_data_in) begin
        fr_next.busy  = 1'b1; // RULE1
        fr_next.shreg = {{(SHIFT_W-1){1'b0}}, 1'b1};
        fr_next.cnt   = 4'h1;
      end
    end else begin
      fr_next.shreg = frm_shifted; // RULE15
      fr_next.cnt   = fr_reg.cnt + 4'h1;
      if (fr_reg.cnt == CFG_EDGE_LAST) begin
        // ninth edge: publish word and flag it to system side
        lk_next.word = frm_shifted; // RULE15
        lk_next.tog  = ~lk_reg.tog;
        fr_next.busy = 1'b0;
        fr_next.cnt  = '0;
      end
    end
  end

  always_ff @(posedge link_clk or negedge frm_clr_b) begin
    if (!frm_clr_b) begin
      fr_reg <= '0;
    end else begin
      fr_reg <= fr_next;
    end
  end

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      lk_reg <= '0;
    end else begin
      lk_reg <= lk_next;
    end
  end

  // result shifter: loads on done toggle, msb first, chain in at lsb
  typedef struct packed {
    logic [RES_W-1:0] sh;
    logic [4:0]       left;
    logic             dout;
  } scp_rd_t;

  scp_rd_t rd_reg;
  scp_rd_t rd_next;
  logic    ack_reg;
  logic    ack_next;

  always_comb begin
    rd_next  = rd_reg;
    ack_next = ack_reg;
    if (!read_select_n && rd_reg.left == '0 && done_tog_l != ack_reg) begin
      // only a finished result is loaded, never a converting one
      rd_next.sh   = res_hold_reg; // RULE9
      rd_next.left = RES_BITS;
      rd_next.dout = res_hold_reg[RES_W-1];
      ack_next     = done_tog_l;
    end else begin
      // chain data follows our lsb once the word is out
      rd_next.sh   = {rd_reg.sh[RES_W-2:0], chain_data_in}; // RULE10
      rd_next.dout = rd_reg.sh[RES_W-2];
      if (rd_reg.left != '0) begin
        rd_next.left = rd_reg.left - 5'h01;
      end
    end
  end

  // deselect clears the shifter; a cut read's result is not loaded again
  always_ff @(posedge link_clk or negedge rd_clr_b) begin
    if (!rd_clr_b) begin
      rd_reg <= '0;
    end else begin
      rd_reg <= rd_next;
    end
  end

  // ack survives deselect so a result is handed over only once
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= ack_next;
    end
  end

  assign result_data_out = rd_reg.dout;

  // ---------------- system domain ----------------
  typedef struct packed {
    logic [SHIFT_W-1:0] cfg;
    logic               tog_seen;
    logic               done_tog;
    logic [RES_W-1:0]   res;
  } scp_sys_t;

  scp_sys_t   sy_reg;
  scp_sys_t   sy_next;
  logic       tog_s;
  logic [1:0] strap_s;
  logic       port_en;

  assign res_hold_reg = sy_reg.res;

  // straps are pins: two flops before use, then gate the apply
  scp_sync #(.W(2)) u_strap_sync (
    .clk   (clk_sys),
    .rst_b (rst_b),
    .d     ({serial_sel, hw_config_sel}),
    .q     (strap_s)
  );

  assign port_en = strap_s[1] & ~strap_s[0]; // RULE18

  scp_sync #(.W(1)) u_tog_sync (
    .clk   (clk_sys),
    .rst_b (rst_b),
    .d     (lk_reg.tog),
    .q     (tog_s)
  );

  // done toggle back into link domain; result word is held stable
  scp_sync #(.W(1)) u_done_sync (
    .clk   (link_clk),
    .rst_b (rst_b),
    .d     (sy_reg.done_tog),
    .q     (done_tog_l)
  );

  always_comb begin
    sy_next = sy_reg;
    if (tog_s != sy_reg.tog_seen) begin
      // word stable since toggle took two syncs to arrive
      sy_next.tog_seen = tog_s;
      // frame seen while strapped off is dropped, not held for later
      if (port_en) begin
        sy_next.cfg[SHIFT_W-1:BIT_CODING] =
          lk_reg.word[SHIFT_W-1:BIT_CODING] & APPLY_MASK; // RULE17
      end
    end
    if (conv_done && !core_sleep) begin
      sy_next.res      = conv_result;
      sy_next.done_tog = ~sy_reg.done_tog; // RULE9
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sy_reg     <= '0;
      sy_reg.cfg <= CFG_RESET; // RULE16
    end else begin
      sy_reg <= sy_next;
    end
  end

  // decoded outputs, registered
  typedef struct packed {
    logic       sleep;
    scp_range_t rng;
    scp_mode_t  mode;
    logic       coding;
    logic [SHIFT_W-1:0] view;
  } scp_out_t;

  scp_out_t ou_reg;
  scp_out_t ou_next;

  always_comb begin
    ou_next        = ou_reg;
    ou_next.view   = sy_reg.cfg;
    ou_next.sleep  = sy_reg.cfg[BIT_SLEEP]; // RULE4 RULE5
    ou_next.coding = sy_reg.cfg[BIT_CODING]; // RULE8
    unique case ({sy_reg.cfg[BIT_BIPOLAR], sy_reg.cfg[BIT_DOUBLE]})
      2'b00: ou_next.rng = SCP_RANGE_0_5; // RULE2
      2'b01: ou_next.rng = SCP_RANGE_0_10; // RULE2
      2'b10: ou_next.rng = SCP_RANGE_PM5; // RULE2
      2'b11: ou_next.rng = SCP_RANGE_PM10; // RULE3
    endcase
    unique case ({sy_reg.cfg[BIT_IMPULSE], sy_reg.cfg[BIT_WARP]})
      2'b00: ou_next.mode = SCP_MODE_NORMAL; // RULE7
      2'b10: ou_next.mode = SCP_MODE_IMPULSE; // RULE7
      2'b01: ou_next.mode = SCP_MODE_WARP; // RULE7
      2'b11: ou_next.mode = SCP_MODE_NORMAL; // RULE7
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ou_reg <= '0;
    end else begin
      ou_reg <= ou_next;
    end
  end

  assign core_sleep        = ou_reg.sleep;
  assign input_range       = ou_reg.rng;
  assign conv_mode         = ou_reg.mode;
  assign output_coding_sel = ou_reg.coding;
  assign cfg_view          = ou_reg.view;
endmodule

/* scp_pkg.sv */
// package: constants and types for the setup serial port block
package scp_pkg;
  localparam int SHIFT_W      = 9;
  localparam int BIT_START    = 8;
  localparam int BIT_BIPOLAR  = 7;
  localparam int BIT_DOUBLE   = 6;
  localparam int BIT_SLEEP    = 5;
  localparam int BIT_IMPULSE  = 4;
  localparam int BIT_WARP     = 3;
  localparam int BIT_CODING   = 2;
  localparam int RES_W        = 16;
  localparam int CNT_W        = 5;
  localparam logic [3:0] CFG_EDGE_LAST = 4'h8;
  localparam logic [4:0] RES_BITS      = 5'h10;
  localparam logic [8:0] CFG_RESET     = 9'h000;
  localparam logic [6:0] APPLY_MASK    = 7'h7F;

  typedef enum logic [1:0] {
    SCP_RANGE_0_5,
    SCP_RANGE_0_10,
    SCP_RANGE_PM5,
    SCP_RANGE_PM10
  } scp_range_t;

  typedef enum logic [1:0] {
    SCP_MODE_NORMAL,
    SCP_MODE_IMPULSE,
    SCP_MODE_WARP
  } scp_mode_t;
endpackage

/* scp_sync.sv */
// module: two flip-flop synchroniser for a group of levels
`timescale 1ns/100ps
module scp_sync
  import scp_pkg::*;
#(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } scp_sync_state_t;

  scp_sync_state_t st_reg;
  scp_sync_state_t st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.s2;
endmodule

/* scp_port_sva.sv */
// checker: setup port assertions
`timescale 1ns/100ps
module scp_port_sva
  import scp_pkg::*;
(
  // clock, reset and port pins
  input wire logic         clk_sys,
  input wire logic         rst_b,
  input wire logic         setup_port_clock,
  input wire logic         setup_port_select_n,
  input wire logic         setup_port_data_in,
  input wire logic         clock_edge_invert,
  input wire logic         serial_sel,
  input wire logic         hw_config_sel,
  // configuration outputs
  input wire logic         core_sleep,
  input wire scp_range_t   input_range,
  input wire scp_mode_t    conv_mode,
  input wire logic         output_coding_sel,
  input wire logic [8:0]   cfg_view
);
  logic       l1, l2, act, done;
  logic [3:0] cnt, age;
  logic [8:0] sh;
  assign act = l1 & ~l2;
  assign done = act && cnt == 4'h8;
  // edges seen late through two flops, so bounds are widened
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      {l1, l2, cnt, age, sh} <= '0;
    end else begin
      l1 <= setup_port_clock ^ clock_edge_invert;
      l2 <= l1;
      if (done) age <= 4'h0;
      else if (age != 4'hF) age <= age + 4'h1;
      if (setup_port_select_n || !serial_sel || hw_config_sel) cnt <= 4'h0;
      else if (act && (cnt != 4'h0 || setup_port_data_in)) begin
        cnt <= (cnt == 4'h9) ? {3'h0, setup_port_data_in} : cnt + 4'h1;
        sh <= {sh[7:0], setup_port_data_in};
      end
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_ninth; done; endsequence
  property p_apply; s_ninth |=> ##[0:6] cfg_view[7:2] == sh[7:2]; endproperty
  a_apply: assert property (p_apply) else $error("word not applied");
  property p_hold; $changed(cfg_view) |-> age < 4'h8; endproperty
  a_hold: assert property (p_hold) else $error("setup changed early");
  property p_rsv; cfg_view[1:0] == 2'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_rst; $rose(rst_b) |-> cfg_view == 9'h000; endproperty
  a_rst: assert property (p_rst) else $error("setup not cleared");
  property p_sleep; $stable(cfg_view) |-> core_sleep == cfg_view[5];
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep wrong");
  property p_range;
    $stable(cfg_view) |-> input_range == scp_range_t'(cfg_view[7:6]);
  endproperty
  a_range: assert property (p_range) else $error("range wrong");
  property p_mode; $stable(cfg_view) |-> conv_mode == ((cfg_view[4]
    ^ cfg_view[3]) ? (cfg_view[4] ? SCP_MODE_IMPULSE : SCP_MODE_WARP)
    : SCP_MODE_NORMAL);
  endproperty
  a_mode: assert property (p_mode) else $error("mode wrong");
  property p_code; $stable(cfg_view) |-> output_coding_sel == cfg_view[2];
  endproperty
  a_code: assert property (p_code) else $error("coding wrong");
endmodule
bind scp_port scp_port_sva u_sva (
  .clk_sys             (clk_sys),
  .rst_b               (rst_b),
  .setup_port_clock    (setup_port_clock),
  .setup_port_select_n (setup_port_select_n),
  .setup_port_data_in  (setup_port_data_in),
  .clock_edge_invert   (clock_edge_invert),
  .serial_sel          (serial_sel),
  .hw_config_sel       (hw_config_sel),
  .core_sleep          (core_sleep),
  .input_range         (input_range),
  .conv_mode           (conv_mode),
  .output_coding_sel   (output_coding_sel),
  .cfg_view            (cfg_view)
);

/* scp_host.sv */
// model: host writing setup words and reading results
`timescale 1ns/100ps
module scp_host (
  // link pins, clock idles low between frames
  output logic      setup_port_clock = 1'b0,
  output logic      setup_port_select_n = 1'b1,
  output logic      setup_port_data_in = 1'b0,
  output logic      read_select_n = 1'b1,
  output logic      chain_data_in = 1'b0,
  // serial result
  input  wire logic result_data_out
);
  task automatic tick();
    #32 setup_port_clock = 1'b1;
    #32 setup_port_clock = 1'b0;
  endtask
  // n bits from w[17] down; fewer than 9 aborts the word
  task automatic write(input logic [17:0] w, input int n);
    setup_port_select_n = 1'b0;
    // data moves mid low phase, clear of both clock edges
    for (int i = 0; i < n; i++) begin
      #16 setup_port_data_in = w[17-i];
      #16 setup_port_clock = 1'b1;
      #32 setup_port_clock = 1'b0;
    end
    #32 setup_port_select_n = 1'b1;
    setup_port_data_in = ~setup_port_data_in;
  endtask
  task automatic read(output logic [16:0] r);
    repeat (3) tick();
    read_select_n = 1'b0;
    chain_data_in = 1'b1;
    for (int i = 0; i < 17; i++) begin
      #32 setup_port_clock = 1'b1;
      #32 r = {r[15:0], result_data_out};
      setup_port_clock = 1'b0;
    end
    read_select_n = 1'b1;
    chain_data_in = 1'b0;
  endtask
endmodule

/* scp_port_tb_top.sv */
// testbench: setup writes, strap gating and result read
`timescale 1ns/100ps
module scp_port_tb_top;
  import scp_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic        clock_edge_invert = 1'b0;
  logic        serial_sel = 1'b1;
  logic        hw_config_sel = 1'b0;
  logic        conv_done = 1'b0;
  logic [15:0] conv_result = 16'h0000;
  logic        setup_port_clock, setup_port_select_n, setup_port_data_in;
  logic        read_select_n, chain_data_in, result_data_out;
  logic        core_sleep, output_coding_sel;
  scp_range_t  input_range;
  scp_mode_t   conv_mode;
  logic [8:0]  cfg_view, w;
  logic [16:0] rd;
  int          error_cnt = 0;
  int          num_checks = 0;
  always #2.5 clk_sys = ~clk_sys;
  scp_port u_dut (
    .clk_sys             (clk_sys),
    .rst_b               (rst_b),
    .setup_port_clock    (setup_port_clock),
    .setup_port_select_n (setup_port_select_n),
    .setup_port_data_in  (setup_port_data_in),
    .clock_edge_invert   (clock_edge_invert),
    .serial_sel          (serial_sel),
    .hw_config_sel       (hw_config_sel),
    .conv_done           (conv_done),
    .conv_result         (conv_result),
    .read_select_n       (read_select_n),
    .chain_data_in       (chain_data_in),
    .result_data_out     (result_data_out),
    .core_sleep          (core_sleep),
    .input_range         (input_range),
    .conv_mode           (conv_mode),
    .output_coding_sel   (output_coding_sel),
    .cfg_view            (cfg_view)
  );
  scp_host u_host (
    .setup_port_clock    (setup_port_clock),
    .setup_port_select_n (setup_port_select_n),
    .setup_port_data_in  (setup_port_data_in),
    .read_select_n       (read_select_n),
    .chain_data_in       (chain_data_in),
    .result_data_out     (result_data_out)
  );
  task automatic chk(input logic [16:0] g, input logic [16:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic logic [16:0] got();
    return {1'b0, core_sleep, input_range, conv_mode, output_coding_sel,
      cfg_view[7:0]};
  endfunction
  function automatic logic [16:0] ex(input logic [8:0] v);
    logic [1:0] m;
    m = (v[4] ^ v[3]) ? (v[4] ? 2'h1 : 2'h2) : 2'h0;
    return {1'b0, v[5], v[7:6], m, v[2], v[7:2], 2'h0};
  endfunction
  task automatic cfg(input logic [17:0] x, input int n, input logic [8:0] e);
    u_host.write(x, n);
    repeat (10) @(negedge clk_sys);
    chk(got(), ex(e));
  endtask
  task automatic final_report();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk_sys);
    rst_b = 1'b1;
    @(negedge clk_sys);
    chk(got(), 17'h00000);
    for (int i = 0; i < 4; i++) begin
      w = {1'b1, i[1:0], i[0], i[1:0], i[1], 2'h3};
      cfg({w, 9'h000}, 9, w);
    end
    @(negedge clk_sys) clock_edge_invert = 1'b1;
    cfg({9'h16C, 9'h000}, 9, 9'h16C);
    @(negedge clk_sys) clock_edge_invert = 1'b0;
    cfg({9'h100, 9'h000}, 5, 9'h16C);
    cfg({9'h1AC, 9'h150}, 18, 9'h150);
    @(negedge clk_sys) hw_config_sel = 1'b1;
    cfg({9'h1FC, 9'h000}, 9, 9'h150);
    @(negedge clk_sys) hw_config_sel = 1'b0;
    serial_sel = 1'b0;
    cfg({9'h1FC, 9'h000}, 9, 9'h150);
    @(negedge clk_sys) serial_sel = 1'b1;
    conv_result = 16'hA5C3;
    conv_done = 1'b1;
    @(negedge clk_sys) conv_done = 1'b0;
    u_host.read(rd);
    chk(rd, {16'hA5C3, 1'b1});
    final_report();
  end
  // run needs about 8 us
  initial begin
    #100000;
    error_cnt++;
    final_report();
  end
endmodule
